// File: verilog/ctrl_port_pkg.sv
// constants and carrier types for the control port and slave port status
package ctrl_port_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_PORT_DATA  = 8'h09;
    localparam logic [7:0] ADDR_PIN_DIR_STATUS     = 8'h89;
    localparam logic [7:0] ADDR_SLAVE_DATA_PORT    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS         = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK           = 8'h8C;
    localparam logic [7:0] ADDR_RMW_OP             = 8'hF0;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_INPUT_BUFFER_FULL  = 7;
    localparam int BIT_OUTPUT_BUFFER_FULL = 6;
    localparam int BIT_INPUT_OVERRUN      = 5;
    localparam int BIT_SLAVE_PORT_ENABLE  = 4;
    localparam int BIT_READ_STROBE_PIN    = 0;
    localparam int BIT_STORE_STROBE_PIN   = 1;
    localparam int BIT_SELECT_PIN         = 2;
    localparam int BIT_IRQ_WRITE_DONE     = 0;
    localparam int BIT_IRQ_READ_DONE      = 1;
    localparam int BIT_IRQ_OVERRUN        = 2;
    localparam int BIT_RMW_SET            = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_DIRECTION   = 3'h7;
    localparam logic [2:0] RST_PORT_LATCH  = 3'h0;
    localparam logic [2:0] RST_IRQ_MASK    = 3'h0;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } pin_drive_t;

endpackage : ctrl_port_pkg

// File: verilog/strobe_edge.sv
// falling/rising detector for one active-low strobe pin
`timescale 1ns/100ps
module strobe_edge (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic level,
    output logic      fall,
    output logic      rise
);
    logic prev_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= level;
        end
    end

    assign fall = prev_r & ~level;
    assign rise = ~prev_r & level;
endmodule : strobe_edge

// File: verilog/control_port.sv
// three-pin control port with slave port direction and status register
`timescale 1ns/100ps
module control_port (
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic                    por_rst,
    input  wire logic [7:0]              bus_addr,
    input  wire logic [7:0]              bus_wdata,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    output logic      [7:0]              bus_rdata,
    input  wire logic [2:0]              pin_in,
    output logic      [2:0]              pin_out,
    output logic      [2:0]              pin_oe,
    input  wire logic [7:0]              slave_data_in,
    output logic      [7:0]              slave_data_out,
    output logic                         slave_data_oe,
    output logic                         irq
);
    // ------------------------------------------------------------------
    // request bundle
    // ------------------------------------------------------------------
    ctrl_port_pkg::reg_req_t   req;
    ctrl_port_pkg::pin_drive_t drive_nxt;

    assign req.addr  = bus_addr;
    assign req.wdata = bus_wdata;
    assign req.wr    = bus_wr;
    assign req.rd    = bus_rd;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0] port_latch_r;
    logic [2:0] direction_r;
    logic       slave_port_enable_r;
    logic       input_buffer_full_r;
    logic       output_buffer_full_r;
    logic       input_overrun_flag_r;
    logic [7:0] slave_in_latch_r;
    logic [7:0] slave_out_latch_r;
    logic [2:0] irq_status_r;
    logic [2:0] irq_mask_r;
    logic       write_active_r;
    logic       read_active_r;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic wr_port;
    logic wr_dir;
    logic wr_slave;
    logic wr_mask;
    logic wr_rmw;
    logic rd_slave;
    logic rd_irq;

    assign wr_port  = req.wr
                   && req.addr == ctrl_port_pkg::ADDR_CONTROL_PORT_DATA;
    assign wr_dir   = req.wr && req.addr == ctrl_port_pkg::ADDR_PIN_DIR_STATUS;
    assign wr_slave = req.wr && req.addr == ctrl_port_pkg::ADDR_SLAVE_DATA_PORT;
    assign wr_mask  = req.wr && req.addr == ctrl_port_pkg::ADDR_IRQ_MASK;
    assign wr_rmw   = req.wr && req.addr == ctrl_port_pkg::ADDR_RMW_OP;
    assign rd_slave = req.rd && req.addr == ctrl_port_pkg::ADDR_SLAVE_DATA_PORT;
    assign rd_irq   = req.rd && req.addr == ctrl_port_pkg::ADDR_IRQ_STATUS;

    // ------------------------------------------------------------------
    // strobe edges of the slave port control pins
    // ------------------------------------------------------------------
    logic rd_req_n;
    logic wr_req_n;
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;

    // strobes only count while selected
    assign rd_req_n = pin_in[ctrl_port_pkg::BIT_READ_STROBE_PIN]
                    | pin_in[ctrl_port_pkg::BIT_SELECT_PIN];
    assign wr_req_n = pin_in[ctrl_port_pkg::BIT_STORE_STROBE_PIN]
                    | pin_in[ctrl_port_pkg::BIT_SELECT_PIN];

    strobe_edge u_rd_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (rd_req_n),
        .fall    (rd_fall),
        .rise    (rd_rise)
    );

    strobe_edge u_wr_edge (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (wr_req_n),
        .fall    (wr_fall),
        .rise    (wr_rise)
    );

    logic ext_rd_start;
    logic ext_rd_done;
    logic ext_wr_start;
    logic ext_wr_done;

    assign ext_rd_start = slave_port_enable_r & rd_fall;
    assign ext_rd_done  = slave_port_enable_r & rd_rise & read_active_r;
    assign ext_wr_start = slave_port_enable_r & wr_fall;
    assign ext_wr_done  = slave_port_enable_r & wr_rise & write_active_r;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            read_active_r  <= 1'b0;
            write_active_r <= 1'b0;
        end else begin
            if (ext_rd_start) begin
                read_active_r <= 1'b1;
            end else if (ext_rd_done || !slave_port_enable_r) begin
                read_active_r <= 1'b0;
            end
            if (ext_wr_start) begin
                write_active_r <= 1'b1;
            end else if (ext_wr_done || !slave_port_enable_r) begin
                write_active_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // control port latch: power-on reset only
    // ------------------------------------------------------------------
    logic [2:0] rmw_value;
    logic [2:0] rmw_bit;

    // modify starts from the pin levels, so input bits load their pins
    always_comb begin
        rmw_bit = 3'h0;
        rmw_bit[req.wdata[1:0] == 2'h3 ? 2'h2 : req.wdata[1:0]] = 1'b1;
        if (req.wdata[ctrl_port_pkg::BIT_RMW_SET]) begin
            rmw_value = pin_in | rmw_bit;
        end else begin
            rmw_value = pin_in & ~rmw_bit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (por_rst) begin
            port_latch_r <= ctrl_port_pkg::RST_PORT_LATCH;
        end else if (wr_port) begin
            port_latch_r <= req.wdata[2:0];
        end else if (wr_rmw) begin
            port_latch_r <= rmw_value;
        end
    end

    // ------------------------------------------------------------------
    // direction and mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            direction_r         <= ctrl_port_pkg::RST_DIRECTION;
            slave_port_enable_r <= 1'b0;
        end else if (wr_dir) begin
            direction_r         <= req.wdata[2:0];
            slave_port_enable_r <=
                req.wdata[ctrl_port_pkg::BIT_SLAVE_PORT_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // slave port buffers and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            slave_in_latch_r <= 8'h00;
        end else if (ext_wr_start || (write_active_r && !ext_wr_done)) begin
            slave_in_latch_r <= slave_data_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            slave_out_latch_r <= 8'h00;
        end else if (wr_slave) begin
            slave_out_latch_r <= req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            input_buffer_full_r <= 1'b0;
        end else if (!slave_port_enable_r) begin
            input_buffer_full_r <= 1'b0;
        end else if (ext_wr_done) begin
            input_buffer_full_r <= 1'b1;
        end else if (rd_slave) begin
            input_buffer_full_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            output_buffer_full_r <= 1'b0;
        end else if (!slave_port_enable_r) begin
            output_buffer_full_r <= 1'b0;
        end else if (ext_rd_start) begin
            output_buffer_full_r <= 1'b0;
        end else if (wr_slave) begin
            output_buffer_full_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            input_overrun_flag_r <= 1'b0;
        end else if (ext_wr_done && input_buffer_full_r && !rd_slave) begin
            input_overrun_flag_r <= 1'b1;
        end else if (wr_dir) begin
            input_overrun_flag_r <=
                req.wdata[ctrl_port_pkg::BIT_INPUT_OVERRUN];
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    logic [2:0] irq_event;

    assign irq_event[ctrl_port_pkg::BIT_IRQ_WRITE_DONE] = ext_wr_done;
    assign irq_event[ctrl_port_pkg::BIT_IRQ_READ_DONE]  = ext_rd_done;
    assign irq_event[ctrl_port_pkg::BIT_IRQ_OVERRUN]    =
        ext_wr_done & input_buffer_full_r & ~rd_slave;

    // set beats the read clear
    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            irq_status_r <= 3'h0;
        end else if (rd_irq) begin
            irq_status_r <= irq_event;
        end else begin
            irq_status_r <= irq_status_r | irq_event;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            irq_mask_r <= ctrl_port_pkg::RST_IRQ_MASK;
        end else if (wr_mask) begin
            irq_mask_r <= req.wdata[2:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // slave data drive
    // ------------------------------------------------------------------
    logic slave_rd_drive;

    // drivers lag the mode bit a cycle; a driven low latch is no read
    assign slave_rd_drive = slave_port_enable_r & ~rd_req_n & ~|pin_oe;

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    always_comb begin
        drive_nxt.out = port_latch_r;
        if (slave_port_enable_r) begin
            drive_nxt.oe = 3'h0;
        end else begin
            drive_nxt.oe = ~direction_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            pin_out        <= 3'h0;
            pin_oe         <= 3'h0;
            slave_data_out <= 8'h00;
            slave_data_oe  <= 1'b0;
        end else begin
            pin_out        <= drive_nxt.out;
            pin_oe         <= drive_nxt.oe;
            slave_data_out <= slave_out_latch_r;
            slave_data_oe  <= slave_rd_drive;
        end
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                ctrl_port_pkg::ADDR_CONTROL_PORT_DATA:
                    bus_rdata <= {5'h00, pin_in};
                ctrl_port_pkg::ADDR_PIN_DIR_STATUS:
                    bus_rdata <= {input_buffer_full_r,
                                  output_buffer_full_r,
                                  input_overrun_flag_r,
                                  slave_port_enable_r,
                                  1'b0, direction_r};
                ctrl_port_pkg::ADDR_SLAVE_DATA_PORT:
                    bus_rdata <= slave_in_latch_r;
                ctrl_port_pkg::ADDR_IRQ_STATUS:
                    bus_rdata <= {5'h00, irq_status_r};
                ctrl_port_pkg::ADDR_IRQ_MASK:
                    bus_rdata <= {5'h00, irq_mask_r};
                default:
                    bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

endmodule : control_port

// File: dv/control_port_properties.sv
// assertions on the control port register bus and pins
`timescale 1ns/100ps
module control_port_properties (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       por_rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [2:0] pin_in,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [7:0] slave_data_in,
    input wire logic [7:0] slave_data_out,
    input wire logic       slave_data_oe,
    input wire logic       irq
);
    logic [1:0] rmw_ix;
    assign rmw_ix = (bus_wdata[1:0] == 2'h3) ? 2'h2 : bus_wdata[1:0];
    logic dir_hit;
    logic mode_seen;
    assign dir_hit = bus_wr && bus_addr == ctrl_port_pkg::ADDR_PIN_DIR_STATUS;
    // mirror of the mode bit, from the register bus alone
    always_ff @(posedge clk_sys) begin
        if (rst || por_rst) begin
            mode_seen <= 1'b0;
        end else if (dir_hit) begin
            mode_seen <= bus_wdata[ctrl_port_pkg::BIT_SLAVE_PORT_ENABLE];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence dir_wr(m);
        bus_wr && bus_addr == ctrl_port_pkg::ADDR_PIN_DIR_STATUS
            && bus_wdata[ctrl_port_pkg::BIT_SLAVE_PORT_ENABLE] == m;
    endsequence
    sequence reg_wr(a);
        bus_wr && bus_addr == a;
    endsequence
    a_port_read: assert property (
        bus_rd && bus_addr == ctrl_port_pkg::ADDR_CONTROL_PORT_DATA
        |=> bus_rdata == {5'h00, $past(pin_in)})
        else $error("port read differs from pin levels");
    a_dir_bit3: assert property (
        $past(bus_rd) && $past(bus_addr) == ctrl_port_pkg::ADDR_PIN_DIR_STATUS
        |-> bus_rdata[3] == 1'b0)
        else $error("unused status bit reads one");
    a_oe_general: assert property (
        dir_wr(1'b0) |-> ##2 pin_oe == ~$past(bus_wdata[2:0], 2))
        else $error("drivers do not follow direction bits");
    a_oe_slave: assert property (
        dir_wr(1'b1) |-> ##2 pin_oe == 3'h0)
        else $error("pins still driven in slave mode");
    a_latch_write: assert property (
        reg_wr(ctrl_port_pkg::ADDR_CONTROL_PORT_DATA)
        |-> ##2 pin_out == $past(bus_wdata[2:0], 2))
        else $error("port latch not written");
    a_modify_bit: assert property (
        reg_wr(ctrl_port_pkg::ADDR_RMW_OP)
        |-> ##2 pin_out[$past(rmw_ix, 2)] == $past(bus_wdata[3], 2))
        else $error("modified bit not in latch");
    a_sel_blocks: assert property (
        pin_in[ctrl_port_pkg::BIT_SELECT_PIN] |=> !slave_data_oe)
        else $error("data driven while deselected");
    a_rd_blocks: assert property (
        pin_in[ctrl_port_pkg::BIT_READ_STROBE_PIN] |=> !slave_data_oe)
        else $error("data driven without read strobe");
    a_oe_read: assert property (
        mode_seen && pin_oe == 3'h0 && (pin_in & 3'h5) == 3'h0
        |=> slave_data_oe)
        else $error("data not driven during selected read");
    a_reset_out: assert property (
        $fell(rst) |-> pin_oe == 3'h0 && irq == 1'b0)
        else $error("outputs not cleared by reset");
endmodule : control_port_properties

bind control_port control_port_properties u_props (
    .clk_sys(clk_sys), .rst(rst), .por_rst(por_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .slave_data_in(slave_data_in),
    .slave_data_out(slave_data_out), .slave_data_oe(slave_data_oe),
    .irq(irq));

// File: dv/ext_master.sv
// behavioural external microprocessor on the slave port pins
`timescale 1ns/100ps
module ext_master (
    input  wire logic       clk_sys,
    input  wire logic [7:0] slave_data_out,
    output logic      [2:0] pins,
    output logic      [7:0] data
);
    initial begin
        pins = 3'h7;
        data = 8'h00;
    end
    // strobe low three cycles, then high three cycles
    task automatic ext_write(input logic [7:0] d, input logic cs_n);
        @(posedge clk_sys);
        pins <= {cs_n, 2'b01};
        data <= d;
        repeat (3) @(posedge clk_sys);
        pins <= 3'h7;
        data <= ~d; // released bus keeps no stale value
        repeat (3) @(posedge clk_sys);
    endtask : ext_write
    task automatic ext_read(input logic cs_n, output logic [7:0] q);
        @(posedge clk_sys);
        pins <= {cs_n, 2'b10};
        repeat (3) @(posedge clk_sys);
        q = slave_data_out;
        pins <= 3'h7;
        repeat (3) @(posedge clk_sys);
    endtask : ext_read
endmodule : ext_master

// File: dv/control_port_tb.sv
// self-checking bench for the control port
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module control_port_tb;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       por_rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic [7:0] bus_rdata, slave_data_in, slave_data_out, q;
    logic [2:0] pin_in, pin_out, pin_oe, ext_pins;
    logic       slave_data_oe, irq;
    int miscompares = 0, checked = 0, cyc = 0;
    int lat = 0, dir = 7, mode = 0, input_buffer_full = 0, output_buffer_full = 0, input_overrun_flag = 0;
    int st = 0, msk = 0, inl = 0, outl = 0;
    always #10 clk_sys = ~clk_sys;
    // wire level from both parties
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);
    control_port dut (.clk_sys(clk_sys), .rst(rst), .por_rst(por_rst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .slave_data_in(slave_data_in),
        .slave_data_out(slave_data_out), .slave_data_oe(slave_data_oe),
        .irq(irq));
    ext_master m (.clk_sys(clk_sys), .slave_data_out(slave_data_out),
        .pins(ext_pins), .data(slave_data_in));
    function automatic int pl();
        return (mode ? ext_pins : (lat & ~dir) | (ext_pins & dir)) & 7;
    endfunction : pl
    function automatic int dv();
        return input_buffer_full << 7 | output_buffer_full << 6 | input_overrun_flag << 5 | mode << 4 | dir;
    endfunction : dv
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int ix;
        ix = (d[1:0] == 2'h3) ? 2 : d[1:0];
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        case (a)
            8'h09: lat = d & 7;
            8'h08: outl = d;
            8'h8C: msk = d & 7;
            8'hF0: lat = d[3] ? pl() | (1 << ix) : pl() & ~(1 << ix);
            default: ;
        endcase
        if (a == 8'h08) output_buffer_full = mode;
        if (a == 8'h89) begin
            input_overrun_flag = d[5];
            mode = d[4];
            dir = d & 7;
            input_buffer_full = input_buffer_full & mode;
            output_buffer_full = output_buffer_full & mode;
        end
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input int e);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        `CHK("bus_rdata", e, bus_rdata)
        if (a == 8'h0C) st = 0;
        if (a == 8'h08) input_buffer_full = 0;
    endtask : rd_chk
    task automatic ext_w(input logic [7:0] d, input logic cs_n);
        m.ext_write(d, cs_n);
        if (!cs_n && mode) begin
            if (input_buffer_full) input_overrun_flag = 1;
            st = st | (input_buffer_full ? 5 : 1);
            input_buffer_full = 1;
            inl = d;
        end
    endtask : ext_w
    task automatic ext_r(input logic cs_n);
        m.ext_read(cs_n, q);
        if (!cs_n && mode) begin
            output_buffer_full = 0;
            st = st | 2;
            `CHK("slave_data_out", outl, q)
        end
    endtask : ext_r
    task automatic settle();
        repeat (2) @(negedge clk_sys);
    endtask : settle
    task wrap_up();
        if (miscompares == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(67));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        por_rst <= 1'b0;
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, 8'h07);
        rd_chk(8'h55, 0);
        `CHK("pin_oe", 0, pin_oe)
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_sys);
            m.pins <= 3'($urandom);
            wr(ctrl_port_pkg::ADDR_CONTROL_PORT_DATA, 8'($urandom));
            wr(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, 8'($urandom) & 8'hEF);
            rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
            rd_chk(ctrl_port_pkg::ADDR_CONTROL_PORT_DATA, pl());
            `CHK("pin_oe", ~dir & 7, pin_oe)
            wr(ctrl_port_pkg::ADDR_RMW_OP, 8'($urandom) & 8'h0F);
            settle();
            `CHK("pin_out", lat, pin_out)
        end
        // ordinary reset keeps the port latch
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        dir = 7;
        input_overrun_flag = 0;
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        wr(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, 8'h00);
        settle();
        rd_chk(ctrl_port_pkg::ADDR_CONTROL_PORT_DATA, pl());
        // slave port traffic
        @(posedge clk_sys);
        m.pins <= 3'h7;
        wr(ctrl_port_pkg::ADDR_IRQ_MASK, 8'h07);
        wr(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, 8'h17);
        settle();
        `CHK("pin_oe", 0, pin_oe)
        wr(ctrl_port_pkg::ADDR_SLAVE_DATA_PORT, 8'($urandom));
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        ext_r(1'b0);
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        ext_w(8'($urandom), 1'b0);
        ext_w(8'($urandom), 1'b0);
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        `CHK("irq", |(st & msk), irq)
        rd_chk(ctrl_port_pkg::ADDR_IRQ_STATUS, st);
        rd_chk(ctrl_port_pkg::ADDR_SLAVE_DATA_PORT, inl);
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        ext_w(8'($urandom), 1'b1);
        ext_r(1'b1);
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        rd_chk(ctrl_port_pkg::ADDR_IRQ_STATUS, st);
        wr(ctrl_port_pkg::ADDR_IRQ_MASK, 8'h01);
        ext_r(1'b0);
        `CHK("irq", |(st & msk), irq)
        ext_w(8'($urandom), 1'b0);
        `CHK("irq", |(st & msk), irq)
        // leaving slave mode clears both buffer flags
        wr(ctrl_port_pkg::ADDR_SLAVE_DATA_PORT, 8'($urandom));
        wr(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, 8'h27);
        rd_chk(ctrl_port_pkg::ADDR_PIN_DIR_STATUS, dv());
        wrap_up();
    end
endmodule : control_port_tb
